//--- hw/ailh_pkg.sv
/*
 Shared constants and carrier types for the analog input lowpass and
 hysteresis conditioner. Assumes samples arrive as signed two's complement
 codes where HYST_MAX stands for 10 V of input span.
*/
// Function
// - Each channel has its own filter state, reference and settings.
// - Hysteresis works on the filter output, never on raw samples.
// - New output is ((N-1) times previous output plus sample) divided by N.
// - N is two to the exponent; exponent zero passes the sample through.
// - Exponent accepts 0 to 16 and resets to 3.
// - Filtered samples within plus/minus width of the reference are discarded.
// - A filtered sample outside the window becomes active value and reference.
// - Hysteresis width spans zero to 10 V code, resets to 0.01 V code.
package ailh_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int unsigned NUM_CH     = 4;
	localparam int unsigned CH_W       = 2;
	localparam int unsigned SAMPLE_W   = 16;
	localparam int unsigned FRAC_W     = 16;
	localparam int unsigned EXP_W      = 5;
	localparam int unsigned FIFO_DEPTH = 8;

	// ---------------------------------------------------------------
	// Setting limits and reset values
	// ---------------------------------------------------------------
	localparam logic [EXP_W-1:0]    EXP_MAX    = 5'h10;
	localparam logic [EXP_W-1:0]    EXP_RESET  = 5'h03;
	// Code 0x7FFF is 10 V; 0.01 V rounds to 0x21
	localparam logic [SAMPLE_W-1:0] HYST_MAX   = 16'h7FFF;
	localparam logic [SAMPLE_W-1:0] HYST_RESET = 16'h0021;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [CH_W-1:0]            channel;
		logic signed [SAMPLE_W-1:0] value;
	} ailh_sample_type;

	typedef struct packed {
		logic [CH_W-1:0]     channel;
		logic [EXP_W-1:0]    exponent;
		logic [SAMPLE_W-1:0] hyst;
	} ailh_cfg_type;

	typedef struct packed {
		logic [CH_W-1:0]            channel;
		logic signed [SAMPLE_W-1:0] filtered;
		logic signed [SAMPLE_W-1:0] active;
		logic                       updated;
	} ailh_result_type;

endpackage : ailh_pkg

//--- hw/ailh_fifo.sv
/*
 Sample FIFO with valid/ready on both sides and registered ready toward the
 writer. Assumes one clock; DEPTH must be a power of two, at least two.
*/
`timescale 1ns/1ps
module ailh_fifo #(
	parameter int unsigned WIDTH = 18,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_bad_size
		$error("ailh_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CNT_W-1:0] count_reg, count_next;
	logic             ready_reg, ready_next;
	logic             push, pop;

	assign push      = in_valid && ready_reg;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign in_ready  = ready_reg;

	always_comb
	begin
		wr_ptr_next = wr_ptr_reg + PTR_W'(push);
		rd_ptr_next = rd_ptr_reg + PTR_W'(pop);
		count_next  = count_reg + CNT_W'(push) - CNT_W'(pop);
		// Registered ready keeps the top output glitch free
		ready_next  = (count_next < CNT_W'(DEPTH));
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
			ready_reg  <= ready_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	a_fifo_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
		count_reg <= CNT_W'(DEPTH))
		else $error("fifo count above depth");

	a_fifo_full_stall: assert property (@(posedge clk) disable iff (sys_rst)
		(count_reg == CNT_W'(DEPTH) && !out_ready) |=> !ready_reg)
		else $error("fifo accepts while full");

endmodule : ailh_fifo

//--- hw/ailh_filter.sv
/*
 Per-channel lowpass filter followed by hysteresis for analog input samples.
 Assumes the converter stream and the settings port share clk; a sample
 whose channel is out of range is consumed and dropped.
*/
`timescale 1ns/1ps
module ailh_filter #(
	parameter int unsigned NUM_CH     = ailh_pkg::NUM_CH,
	parameter int unsigned FIFO_DEPTH = ailh_pkg::FIFO_DEPTH
) (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic                      smp_valid,
	input  wire ailh_pkg::ailh_sample_type smp_data,
	output logic                           smp_ready,
	input  wire logic                      cfg_valid,
	input  wire ailh_pkg::ailh_cfg_type    cfg_data,
	output logic                           cfg_reject,
	output logic                           res_valid,
	output ailh_pkg::ailh_result_type      res_data,
	input  wire logic                      res_ready
);
	import ailh_pkg::*;

	localparam int unsigned ACC_W = SAMPLE_W + FRAC_W;

	// Channel field must be able to address every channel
	if (NUM_CH < 1 || NUM_CH > (1 << CH_W))
	begin : g_bad_channels
		$error("ailh_filter: NUM_CH out of range");
	end

	// ---------------------------------------------------------------
	// Input buffer
	// ---------------------------------------------------------------
	ailh_sample_type head;
	logic            head_valid;
	logic            pop;

	ailh_fifo #(
		.WIDTH ($bits(ailh_sample_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (smp_valid),
		.in_data   (smp_data),
		.in_ready  (smp_ready),
		.out_valid (head_valid),
		.out_data  (head),
		.out_ready (pop)
	);

	// ---------------------------------------------------------------
	// Channel state
	// ---------------------------------------------------------------
	logic signed [ACC_W-1:0]    acc_reg  [NUM_CH];
	logic signed [ACC_W-1:0]    acc_next [NUM_CH];
	logic signed [SAMPLE_W-1:0] ref_reg  [NUM_CH];
	logic signed [SAMPLE_W-1:0] ref_next [NUM_CH];
	logic [EXP_W-1:0]           exp_reg  [NUM_CH];
	logic [EXP_W-1:0]           exp_next [NUM_CH];
	logic [SAMPLE_W-1:0]        hyst_reg [NUM_CH];
	logic [SAMPLE_W-1:0]        hyst_next[NUM_CH];
	logic [NUM_CH-1:0]          prim_reg, prim_next;
	logic                       res_valid_reg, res_valid_next;
	ailh_result_type            res_reg, res_next;
	logic                       cfg_reject_reg, cfg_reject_next;

	// ---------------------------------------------------------------
	// Datapath for the sample at the buffer head
	// ---------------------------------------------------------------
	logic                       ch_ok;
	logic [CH_W-1:0]            idx;
	logic signed [ACC_W-1:0]    x_ext, cur_acc, acc_new;
	logic signed [ACC_W:0]      delta, step;
	logic signed [SAMPLE_W-1:0] filt, cur_ref;
	logic signed [SAMPLE_W:0]   hdiff;
	logic [SAMPLE_W:0]          habs;
	logic                       outside, cur_prim, cfg_ok;

	assign pop      = head_valid && (!res_valid_reg || res_ready);
	assign ch_ok    = (int'(head.channel) < NUM_CH);
	assign idx      = ch_ok ? head.channel : '0;
	assign cur_acc  = acc_reg[idx];
	assign cur_ref  = ref_reg[idx];
	assign cur_prim = prim_reg[idx];
	assign x_ext    = {head.value, {FRAC_W{1'b0}}};
	// y + (x - y) / N equals ((N-1)y + x) / N; shift floors toward minus
	assign delta    = {x_ext[ACC_W-1], x_ext} - {cur_acc[ACC_W-1], cur_acc};
	assign step     = delta >>> exp_reg[idx];
	// Result lies between y and x, so the cut to ACC_W cannot wrap
	assign acc_new  = cur_prim ? cur_acc + step[ACC_W-1:0] : x_ext;
	assign filt     = acc_new[ACC_W-1:FRAC_W];
	assign hdiff    = {filt[SAMPLE_W-1], filt} - {cur_ref[SAMPLE_W-1], cur_ref};
	assign habs     = hdiff[SAMPLE_W] ? (SAMPLE_W+1)'(-hdiff) : hdiff;
	assign outside  = habs > {1'b0, hyst_reg[idx]};
	assign cfg_ok   = (int'(cfg_data.channel) < NUM_CH) && (cfg_data.exponent <= EXP_MAX)
	                  && (cfg_data.hyst <= HYST_MAX);

	always_comb
	begin
		acc_next        = acc_reg;
		ref_next        = ref_reg;
		exp_next        = exp_reg;
		hyst_next       = hyst_reg;
		prim_next       = prim_reg;
		res_next        = res_reg;
		res_valid_next  = res_valid_reg && !res_ready;
		cfg_reject_next = 1'b0;
		if (pop && ch_ok)
		begin
			// Only the addressed channel changes state
			acc_next[idx]      = acc_new;
			prim_next[idx]     = 1'b1;
			res_valid_next     = 1'b1;
			res_next.channel   = idx;
			res_next.filtered  = filt;
			res_next.updated   = 1'b0;
			if (!cur_prim || outside)
			begin
				ref_next[idx]     = filt;
				res_next.active   = filt;
				res_next.updated  = 1'b1;
			end
			else
				res_next.active   = cur_ref;
		end
		if (cfg_valid)
		begin
			if (cfg_ok)
			begin
				exp_next[cfg_data.channel]  = cfg_data.exponent;
				hyst_next[cfg_data.channel] = cfg_data.hyst;
			end
			else
				cfg_reject_next = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				acc_reg[i]  <= '0;
				ref_reg[i]  <= '0;
				exp_reg[i]  <= EXP_RESET;
				hyst_reg[i] <= HYST_RESET;
			end
			prim_reg       <= '0;
			res_valid_reg  <= 1'b0;
			res_reg        <= '0;
			cfg_reject_reg <= 1'b0;
		end
		else
		begin
			acc_reg        <= acc_next;
			ref_reg        <= ref_next;
			exp_reg        <= exp_next;
			hyst_reg       <= hyst_next;
			prim_reg       <= prim_next;
			res_valid_reg  <= res_valid_next;
			res_reg        <= res_next;
			cfg_reject_reg <= cfg_reject_next;
		end
	end

	assign res_valid  = res_valid_reg;
	assign res_data   = res_reg;
	assign cfg_reject = cfg_reject_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_first_sample;
		pop && ch_ok && !cur_prim;
	endsequence

	sequence s_primed_sample;
		pop && ch_ok && cur_prim;
	endsequence

	a_first_load: assert property (s_first_sample |=>
		res_valid && res_data.updated && res_data.active == $past(head.value)
		&& res_data.filtered == $past(head.value))
		else $error("first sample not loaded directly");

	a_order_zero: assert property ((s_primed_sample and exp_reg[idx] == 5'h00)
		|=> res_data.filtered == $past(head.value))
		else $error("exponent zero does not pass sample");

	a_hyst_hold: assert property ((s_primed_sample and !outside)
		|=> !res_data.updated && ref_reg[$past(idx)] == $past(cur_ref)
		&& res_data.active == ref_reg[res_data.channel])
		else $error("sample inside window was not discarded");

	a_hyst_adopt: assert property ((s_primed_sample and outside)
		|=> res_data.updated && res_data.active == res_data.filtered
		&& ref_reg[res_data.channel] == res_data.filtered)
		else $error("sample outside window not adopted");

	a_active_source: assert property (res_valid |->
		res_data.active == ref_reg[res_data.channel])
		else $error("active value not from filtered path");

	a_exp_range: assert property (cfg_valid && cfg_data.exponent > EXP_MAX
		|=> cfg_reject && $stable(exp_reg[0]) && $stable(exp_reg[NUM_CH-1]))
		else $error("illegal exponent accepted");

	a_hyst_range: assert property (cfg_valid && cfg_data.hyst > HYST_MAX
		|=> cfg_reject && $stable(hyst_reg[0]) && $stable(hyst_reg[NUM_CH-1])
		&& hyst_reg[0] <= HYST_MAX)
		else $error("illegal hysteresis accepted");

	a_chan_isolate: assert property (pop && ch_ok && idx != '0
		|=> $stable(acc_reg[0]) && $stable(ref_reg[0]))
		else $error("other channel state disturbed");

	a_step_mean: assert property ((s_primed_sample and head.value == cur_ref
		and cur_acc == x_ext) |=> res_data.filtered == $past(head.value))
		else $error("settled filter drifts");

endmodule : ailh_filter

//--- sim/ailh_conv_model.sv
/*
 Converter model: offers queued samples on the valid/ready stream.
 Assumes the bench queues samples with send() and sets gap for slow pacing.
*/
`timescale 1ns/1ps
module ailh_conv_model (
	input  wire logic                 clk,
	input  wire logic                 gap,
	output logic                      smp_valid,
	output ailh_pkg::ailh_sample_type smp_data,
	input  wire logic                 smp_ready
);
	import ailh_pkg::*;
	ailh_sample_type q[$];
	logic            took;

	task send(input logic [1:0] ch, input logic [15:0] v);
		q.push_back({ch, v});
	endtask : send

	initial
	begin
		smp_valid = 1'h0;
		smp_data = '0;
		@(posedge clk);
		forever
		begin
			#2;
			if (q.size() == 0)
			begin
				smp_valid = 1'h0;
				// Idle bus alternates between the last sample and its complement
				smp_data = ~smp_data;
				@(posedge clk);
			end
			else
			begin
				smp_valid = 1'h1;
				smp_data = q[0];
				do
				begin
					@(negedge clk);
					took = smp_ready;
					@(posedge clk);
				end
				while (!took);
				q.delete(0);
				if (gap)
				begin
					#2;
					smp_valid = 1'h0;
					smp_data = ~smp_data;
					@(posedge clk);
				end
			end
		end
	end
endmodule : ailh_conv_model

//--- sim/ailh_filter_tb_top.sv
/*
 Bench for the lowpass and hysteresis conditioner.
 Assumes the converter model in ailh_conv_model and a 50 ns clock.
*/
`timescale 1ns/1ps
module ailh_filter_tb_top;
	import ailh_pkg::*;
	logic            clk, sys_rst, gap, cfg_valid, cfg_reject;
	logic            smp_valid, smp_ready, res_valid, res_ready;
	ailh_sample_type smp_data;
	ailh_cfg_type    cfg_data;
	ailh_result_type res_data;
	int              miscompares, cmp_count;

	ailh_filter uut (.clk(clk), .sys_rst(sys_rst), .smp_valid(smp_valid), .smp_data(smp_data),
		.smp_ready(smp_ready), .cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_reject(cfg_reject),
		.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
	ailh_conv_model model (.clk(clk), .gap(gap), .smp_valid(smp_valid), .smp_data(smp_data),
		.smp_ready(smp_ready));

	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ----------
	// Helpers
	// ----------
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task bad(input string m);
		$display("BAD %0t %s", $time, m);
		miscompares++;
		cmp_count++;
	endtask : bad

	task good;
		cmp_count++;
	endtask : good

	task cfg(input logic [1:0] ch, input logic [4:0] e, input logic [15:0] h, input logic rej);
		@(posedge clk);
		#2;
		cfg_valid = 1'h1;
		cfg_data = {ch, e, h};
		@(posedge clk);
		#2;
		cfg_valid = 1'h0;
		if (cfg_reject !== rej) bad("settings refusal"); else good();
	endtask : cfg

	// Bounded wait, then one result taken at the next edge
	task exp_res(input logic [1:0] ch, input logic [15:0] f, input logic [15:0] a, input logic u);
		int n;
		@(negedge clk);
		for (n = 0; n < 200 && res_valid !== 1'h1; n++) @(negedge clk);
		if (n == 200)
		begin
			bad("no result");
			end_sim();
		end
		if (res_data !== {ch, f, a, u}) bad("result fields"); else good();
		@(posedge clk);
	endtask : exp_res

	// ----------
	// Scenarios
	// ----------
	task t_reset;
		repeat (4) @(posedge clk);
		#2;
		if (smp_ready !== 1'h0 || res_valid !== 1'h0 || cfg_reject !== 1'h0) bad("reset outputs"); else good();
		sys_rst = 1'h0;
		@(posedge clk);
		#2;
		if (smp_ready !== 1'h1) bad("ready after reset"); else good();
		$display("test reset done");
	endtask : t_reset

	task t_default;
		gap = 1'h1;
		model.send(2'h0, 16'h1000);
		model.send(2'h0, 16'h1800);
		model.send(2'h0, 16'h1110);
		model.send(2'h0, 16'h11FA);
		model.send(2'h0, 16'h1129);
		exp_res(2'h0, 16'h1000, 16'h1000, 1'h1);
		exp_res(2'h0, 16'h1100, 16'h1100, 1'h1);
		exp_res(2'h0, 16'h1102, 16'h1100, 1'h0);
		exp_res(2'h0, 16'h1121, 16'h1100, 1'h0);
		exp_res(2'h0, 16'h1122, 16'h1122, 1'h1);
		gap = 1'h0;
		$display("test default done");
	endtask : t_default

	task t_cfg;
		cfg(2'h1, 5'h00, 16'h0000, 1'h0);
		cfg(2'h1, 5'h11, 16'h0000, 1'h1);
		cfg(2'h1, 5'h00, 16'h8000, 1'h1);
		cfg(2'h2, EXP_MAX, HYST_MAX, 1'h0);
		model.send(2'h1, 16'h0100);
		model.send(2'h1, 16'hFF00);
		model.send(2'h2, 16'h0000);
		model.send(2'h2, 16'h4000);
		exp_res(2'h1, 16'h0100, 16'h0100, 1'h1);
		exp_res(2'h1, 16'hFF00, 16'hFF00, 1'h1);
		exp_res(2'h2, 16'h0000, 16'h0000, 1'h1);
		exp_res(2'h2, 16'h0000, 16'h0000, 1'h0);
		$display("test settings done");
	endtask : t_cfg

	task t_fill;
		logic [15:0]     v;
		int              n;
		ailh_result_type r;
		cfg(2'h3, 5'h00, 16'h0000, 1'h0);
		res_ready = 1'h0;
		for (v = 16'h0200; v < 16'h020C; v++) model.send(2'h3, v);
		// Consumer stalls until the buffer refuses
		for (n = 0; n < 50 && smp_ready !== 1'h0; n++) @(negedge clk);
		if (n == 50)
		begin
			bad("buffer never full");
			end_sim();
		end
		else
			good();
		r = res_data;
		repeat (3) @(negedge clk);
		if (res_valid !== 1'h1 || res_data !== r || smp_ready !== 1'h0) bad("held result"); else good();
		@(posedge clk);
		#2;
		res_ready = 1'h1;
		for (v = 16'h0200; v < 16'h020C; v++) exp_res(2'h3, v, v, 1'h1);
		@(negedge clk);
		if (smp_ready !== 1'h1 || res_valid !== 1'h0) bad("drained state"); else good();
		$display("test fill done");
	endtask : t_fill

	// Reset in mid-run must restore defaults and re-prime; only channel 2 is driven and checked
	task t_rerun;
		@(posedge clk);
		#2;
		sys_rst = 1'h1;
		repeat (4) @(posedge clk);
		#2;
		if (smp_ready !== 1'h0 || res_valid !== 1'h0 || cfg_reject !== 1'h0) bad("mid-run reset outputs"); else good();
		sys_rst = 1'h0;
		model.send(2'h2, 16'h1000);
		model.send(2'h2, 16'h1800);
		exp_res(2'h2, 16'h1000, 16'h1000, 1'h1);
		exp_res(2'h2, 16'h1100, 16'h1100, 1'h1);
		$display("test reset rerun done");
	endtask : t_rerun

	initial
	begin
		sys_rst = 1'h1;
		gap = 1'h0;
		cfg_valid = 1'h0;
		cfg_data = '0;
		res_ready = 1'h1;
		miscompares = 0;
		cmp_count = 0;
		t_reset();
		t_default();
		t_cfg();
		t_fill();
		t_rerun();
		end_sim();
	end
endmodule : ailh_filter_tb_top
